// File: ctsg_pkg.sv
// package: offsets, reset values, bus codes and phase type for the cross-trigger status/gate block
package ctsg_pkg;

    // channel count of the cross-trigger unit, one bit per channel in every field
    localparam int          NUM_CHAN       = 4;

    // register offsets within the 4 KB debug frame (byte addresses)
    localparam logic [11:0] OFS_TRIG_STAT  = 12'h134;
    localparam logic [11:0] OFS_CHAN_STAT  = 12'h138;
    localparam logic [11:0] OFS_GATE       = 12'h140;
    localparam logic [11:0] OFS_TRACE_PSEL = 12'h150;
    localparam logic [11:0] OFS_ARCH       = 12'hfbc;
    localparam logic [11:0] OFS_CAPABILITY_CONFIG      = 12'hfc8;
    localparam logic [11:0] OFS_COMPONENT_TYPE    = 12'hfcc;
    localparam logic [11:0] OFS_PID4       = 12'hfd0;
    localparam logic [11:0] OFS_PID5       = 12'hfd4;
    localparam logic [11:0] OFS_PID6       = 12'hfd8;
    localparam logic [11:0] OFS_PID7       = 12'hfdc;
    localparam logic [11:0] OFS_PID0       = 12'hfe0;
    localparam logic [11:0] OFS_PID1       = 12'hfe4;
    localparam logic [11:0] OFS_PID2       = 12'hfe8;
    localparam logic [11:0] OFS_PID3       = 12'hfec;
    localparam logic [11:0] OFS_CID0       = 12'hff0;
    localparam logic [11:0] OFS_CID1       = 12'hff4;
    localparam logic [11:0] OFS_CID2       = 12'hff8;
    localparam logic [11:0] OFS_CID3       = 12'hffc;

    // values after reset and fixed field values
    localparam logic [3:0]  GATE_RST       = 4'hf;
    localparam logic [3:0]  MINOR_REV_RST  = 4'h0;
    localparam logic [3:0]  CUSTOMER_MODIFIED_UNMOD     = 4'h0;

    // bus codes
    localparam logic [2:0]  HSIZE_WORD     = 3'h2;
    localparam logic        HRESP_OKAY     = 1'b0;

    // bus data-phase tracker, one-hot
    typedef enum logic [2:0] {
        CTSG_PH_IDLE  = 3'h1,
        CTSG_PH_WRITE = 3'h2,
        CTSG_PH_READ  = 3'h4
    } ctsg_phase_t;

endpackage : ctsg_pkg

// File: ctsg_chan_if.sv
// interface: channel signals between the register bank and the channel gate
`timescale 1ns/1ps
interface ctsg_chan_if;
    import ctsg_pkg::*;
    logic                ce;          // clock enable
    logic [NUM_CHAN-1:0] gate;        // propagation gate, 1 = pass
    logic [NUM_CHAN-1:0] local_ev;    // local channel events
    logic [NUM_CHAN-1:0] matrix_in;   // channels from the matrix
    logic [NUM_CHAN-1:0] matrix_out;  // gated channels to the matrix
    logic [NUM_CHAN-1:0] local_view;  // channels seen by local triggers
    logic [NUM_CHAN-1:0] chan_status; // sampled incoming channels

    // register bank side
    modport bank (output ce, gate, local_ev, matrix_in,
                  input  matrix_out, local_view, chan_status);
    // channel gate side
    modport chan (input  ce, gate, local_ev, matrix_in,
                  output matrix_out, local_view, chan_status);
endinterface : ctsg_chan_if

// File: ctsg_chan_gate.sv
// module: channel propagation gate and incoming channel sampler
`timescale 1ns/1ps
module ctsg_chan_gate
    import ctsg_pkg::*;
(
    input  wire logic hclk,
    input  wire logic hresetn,
    ctsg_chan_if.chan ch
);

    // all state of the gate in one record
    typedef struct packed {
        logic [NUM_CHAN-1:0] matrix_out;  // registered toward the matrix
        logic [NUM_CHAN-1:0] local_view;  // registered toward local triggers
        logic [NUM_CHAN-1:0] chan_status; // registered incoming levels
    } ctsg_gate_st_t;

    ctsg_gate_st_t st_r;
    ctsg_gate_st_t st_nxt;

    // next state; frozen while the enable is low
    always_comb
    begin
        st_nxt = st_r;
        if (ch.ce)
        begin
            // a closed gate bit keeps that channel off the matrix
            st_nxt.matrix_out  = ch.local_ev & ch.gate;
            // local triggers still see local events, gate or not
            st_nxt.local_view  = ch.local_ev | ch.matrix_in;
            st_nxt.chan_status = ch.matrix_in;
        end
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign ch.matrix_out  = st_r.matrix_out;
    assign ch.local_view  = st_r.local_view;
    assign ch.chan_status = st_r.chan_status;

    // closed channels never reach the matrix
    gate_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ch.ce |=> (ch.matrix_out & ~$past(ch.gate)) == '0)
        else $error("closed channel reached the matrix");

    // with all gates closed local events still reach local triggers
    local_pass_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ch.ce && ch.gate == '0 && ch.local_ev != '0) |=> (ch.local_view != '0) && (ch.matrix_out == '0))
        else $error("local event lost or leaked with gate closed");

endmodule : ctsg_chan_gate

// File: ctsg_top.sv
// module: AHB-Lite register bank for trigger/channel status, channel gate and identification
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps

module ctsg_top
    import ctsg_pkg::*;
#(
    parameter int          NUM_TRIG     = 8,       // trigger outputs
    parameter logic [11:0] PART_NUM     = 12'h000, // arbitrary value
    parameter logic [7:0]  DESIGNER     = 8'h00,   // arbitrary value
    parameter logic [3:0]  DESIGNER_CNT = 4'h0,    // arbitrary value
    parameter logic [3:0]  MEM_SIZE     = 4'h0,    // frame count code
    parameter logic [3:0]  REVISION     = 4'h0,    // arbitrary value
    parameter logic [31:0] DEV_ARCH     = 32'h0000_0000, // arbitrary value
    parameter logic [7:0]  DEV_TYPE     = 8'h00,   // arbitrary value
    parameter logic [3:0]  COMP_CLASS   = 4'h0,    // arbitrary value
    parameter logic [31:0] CID_BYTES    = 32'h0000_0000, // arbitrary value
    parameter logic [4:0]  TRACE_PIN    = 5'h00    // fixed trace pin
)
(
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                ce,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic                hready,
    input  wire logic [31:0]         hwdata,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    input  wire logic [NUM_TRIG-1:0] trig_out_level,
    input  wire logic [NUM_CHAN-1:0] chan_local_ev,
    input  wire logic [NUM_CHAN-1:0] chan_matrix_in,
    output logic [NUM_CHAN-1:0]      chan_matrix_out,
    output logic [NUM_CHAN-1:0]      chan_local_view
);

    // identification words assembled from the parameters
    localparam logic [31:0] PID0_VAL  = {24'h000000, PART_NUM[7:0]};
    localparam logic [31:0] PID1_VAL  = {24'h000000, DESIGNER[3:0], PART_NUM[11:8]};
    localparam logic [31:0] PID2_VAL  = {24'h000000, REVISION, DESIGNER[7:4]};
    localparam logic [31:0] PID4_VAL  = {24'h000000, MEM_SIZE, DESIGNER_CNT};
    localparam logic [31:0] TYPE_VAL  = {24'h000000, DEV_TYPE};
    // capability word: trigger count in bits 15:8, channel count in 19:16
    localparam logic [31:0] CAPABILITY_CONFIG_VAL = {12'h000, 4'(NUM_CHAN), 8'(NUM_TRIG), 8'h00};
    localparam logic [31:0] CID0_VAL  = {24'h000000, CID_BYTES[7:0]};
    localparam logic [31:0] CID1_VAL  = {24'h000000, COMP_CLASS, CID_BYTES[11:8]};
    localparam logic [31:0] CID2_VAL  = {24'h000000, CID_BYTES[23:16]};
    localparam logic [31:0] CID3_VAL  = {24'h000000, CID_BYTES[31:24]};

    // all state of the bank in one record
    typedef struct packed {
        ctsg_phase_t         phase;     // current data phase
        logic [11:0]         addr;      // offset held for the data phase
        logic [NUM_CHAN-1:0] gate;      // propagation gate
        logic [3:0]          minor_rev; // late-fix field, resets to zero
        logic [31:0]         rdata;     // read data for the data phase
    } ctsg_bank_st_t;

    ctsg_bank_st_t st_r;
    ctsg_bank_st_t st_nxt;

    // offset match, used by decode, forwarding and checks
    function automatic logic ctsg_hit(input logic [11:0] a, input logic [11:0] ofs);
        ctsg_hit = (a == ofs);
    endfunction : ctsg_hit

    logic                ch_acc;     // address phase taken this cycle
    logic                ch_wr_acc;  // taken write of a whole word
    logic [11:0]         ch_ofs;     // offset of the address phase
    logic [NUM_CHAN-1:0] gate_view;  // gate value with a pending write forwarded
    logic [31:0]         rd_val;     // decoded read value
    logic [NUM_CHAN-1:0] chan_stat;  // incoming channel status from the gate

    ctsg_chan_if ch_if ();

    // channel gate instance
    ctsg_chan_gate u_gate (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ch      (ch_if.chan)
    );

    // feed the gate from the bank and the pins
    assign ch_if.ce        = ce;
    assign ch_if.gate      = st_r.gate;
    assign ch_if.local_ev  = chan_local_ev;
    assign ch_if.matrix_in = chan_matrix_in;
    assign chan_matrix_out = ch_if.matrix_out;
    assign chan_local_view = ch_if.local_view;
    assign chan_stat       = ch_if.chan_status;

    // the bank never waits except while frozen; stalling keeps the master from losing a beat
    assign hreadyout = ce;
    assign hresp     = HRESP_OKAY;
    assign hrdata    = st_r.rdata;

    // address phase decode
    assign ch_ofs    = haddr[11:0];
    assign ch_acc    = hsel && htrans[1] && hready && ce;
    assign ch_wr_acc = ch_acc && hwrite && (hsize == HSIZE_WORD);

    // gate forwarding: a read right behind a gate write sees the new value
    always_comb
    begin
        gate_view = st_r.gate;
        if (st_r.phase == CTSG_PH_WRITE && ctsg_hit(st_r.addr, OFS_GATE))
            gate_view = hwdata[NUM_CHAN-1:0];
    end

    // read decode; reads have no side effect on any state
    always_comb
    begin
        rd_val = 32'h0000_0000;
        case (ch_ofs)
            OFS_TRIG_STAT:  rd_val = 32'(trig_out_level);
            OFS_CHAN_STAT:  rd_val = 32'(chan_stat);
            OFS_GATE:       rd_val = 32'(gate_view);
            OFS_TRACE_PSEL: rd_val = 32'(TRACE_PIN);
            OFS_ARCH:       rd_val = DEV_ARCH;
            OFS_CAPABILITY_CONFIG:      rd_val = CAPABILITY_CONFIG_VAL;
            OFS_COMPONENT_TYPE:    rd_val = TYPE_VAL;
            OFS_PID4:       rd_val = PID4_VAL;
            OFS_PID0:       rd_val = PID0_VAL;
            OFS_PID1:       rd_val = PID1_VAL;
            OFS_PID2:       rd_val = PID2_VAL;
            // customer field fixed, minor revision from its own storage
            OFS_PID3:       rd_val = {24'h000000, st_r.minor_rev, CUSTOMER_MODIFIED_UNMOD};
            OFS_CID0:       rd_val = CID0_VAL;
            OFS_CID1:       rd_val = CID1_VAL;
            OFS_CID2:       rd_val = CID2_VAL;
            OFS_CID3:       rd_val = CID3_VAL;
            // PID5 to PID7 and unmapped offsets read zero
            default:        rd_val = 32'h0000_0000;
        endcase
    end

    // next state of the bank; nothing moves while the enable is low
    always_comb
    begin
        st_nxt = st_r;
        if (ce)
        begin
            // finish a write data phase: only the gate takes data
            if (st_r.phase == CTSG_PH_WRITE)
            begin
                if (ctsg_hit(st_r.addr, OFS_GATE))
                    st_nxt.gate = hwdata[NUM_CHAN-1:0];
                // every other offset drops the data, pin select included
            end
            // minor revision only ever holds its reset value
            st_nxt.minor_rev = st_r.minor_rev;
            // open the next data phase
            if (ch_wr_acc)
            begin
                st_nxt.phase = CTSG_PH_WRITE;
                st_nxt.addr  = ch_ofs;
            end
            else if (ch_acc && !hwrite)
            begin
                st_nxt.phase = CTSG_PH_READ;
                st_nxt.addr  = ch_ofs;
                st_nxt.rdata = rd_val;
            end
            else
            begin
                // idle, busy or narrow writes: nothing to do
                st_nxt.phase = CTSG_PH_IDLE;
            end
        end
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_r.phase     <= CTSG_PH_IDLE;
            st_r.addr      <= 12'h000;
            st_r.gate      <= GATE_RST;
            st_r.minor_rev <= MINOR_REV_RST;
            st_r.rdata     <= 32'h0000_0000;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // gate opens fully out of reset
    gate_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> (st_r.gate == GATE_RST) && (chan_matrix_out == '0))
        else $error("gate not all open after reset");

    // a gate write lands when its data phase completes
    gate_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ch_wr_acc && ctsg_hit(ch_ofs, OFS_GATE)) ##1 ce |=> st_r.gate == $past(hwdata[NUM_CHAN-1:0]))
        else $error("gate write not applied");

    // writes elsewhere leave the gate untouched
    ro_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ch_acc && hwrite && !ctsg_hit(ch_ofs, OFS_GATE)) ##1 ce |=> $stable(st_r.gate))
        else $error("write to read-only offset changed the gate");

    // trigger status returns the levels seen in the address phase
    trig_status_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ch_acc && !hwrite && ctsg_hit(ch_ofs, OFS_TRIG_STAT)) |=> hrdata == 32'($past(trig_out_level)))
        else $error("trigger status read wrong");

    // channel status follows the matrix input with one cycle of sampling
    chan_status_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce ##1 (ch_acc && !hwrite && ctsg_hit(ch_ofs, OFS_CHAN_STAT))) |=> hrdata == 32'($past(chan_matrix_in, 2)))
        else $error("channel status read wrong");

    // part number and designer nibble come back from the second id word
    part_id_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ch_acc && !hwrite && ctsg_hit(ch_ofs, OFS_PID1)) |=> hrdata[3:0] == PART_NUM[11:8] && hrdata[7:4] == DESIGNER[3:0])
        else $error("part number field wrong");

    // customer and minor revision fields both read zero
    rev_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ch_acc && !hwrite && ctsg_hit(ch_ofs, OFS_PID3)) |=> hrdata == 32'h0000_0000)
        else $error("revision fields not zero");

    // component class sits in the second component word
    comp_class_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ch_acc && !hwrite && ctsg_hit(ch_ofs, OFS_CID1)) |=> hrdata[7:4] == COMP_CLASS)
        else $error("component class wrong");

    // upper peripheral words PID5 and PID7 read zero
    id_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ch_acc && !hwrite && (ctsg_hit(ch_ofs, OFS_PID5) || ctsg_hit(ch_ofs, OFS_PID7))) |=> hrdata == 32'h0000_0000)
        else $error("unspecified id word not zero");

    // pin select keeps its fixed pin after any write
    psel_fixed_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ch_acc && !hwrite && ctsg_hit(ch_ofs, OFS_TRACE_PSEL)) |=> hrdata == 32'(TRACE_PIN))
        else $error("trace pin select moved");

    // the bank stalls only while frozen and always answers okay
    bus_ready_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (hreadyout == ce) && (hresp == HRESP_OKAY))
        else $error("bad bus response");

endmodule : ctsg_top

// File: ctsg_matrix_model.sv
// partner model: channel matrix joining this unit to the other cross-trigger units
`timescale 1ns/1ps
module ctsg_matrix_model
    import ctsg_pkg::*;
(
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic [NUM_CHAN-1:0] from_unit, // gated channels of the unit
    input  wire logic [NUM_CHAN-1:0] ext_ev,    // events of other units
    input  wire logic                slow,      // one extra cycle of latency
    output logic      [NUM_CHAN-1:0] to_unit    // broadcast back to the unit
);
    logic [NUM_CHAN-1:0] stage_r; // first matrix stage
    logic [NUM_CHAN-1:0] late_r;  // second stage for slow answers

    // broadcast is the or of all units, own contribution included
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            stage_r <= '0;
            late_r  <= '0;
        end
        else
        begin
            stage_r <= from_unit | ext_ev;
            late_r  <= stage_r;
        end
    end

    // slow mode models a longer route through the matrix
    assign to_unit = slow ? late_r : stage_r;
endmodule : ctsg_matrix_model

// File: ctsg_top_test.sv
// testbench: status, gate and identification registers of the cross-trigger block
`timescale 1ns/1ps
module ctsg_top_test;
    import ctsg_pkg::*;
    localparam logic [31:0] CID = 32'h7766_9544; // arbitrary value
    logic        hclk    = 1'b0;
    logic        hresetn = 1'b0;
    logic        ce      = 1'b1;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = '0;
    logic [1:0]  htrans  = 2'b00;
    logic        hwrite  = 1'b0;
    logic [2:0]  hsize   = HSIZE_WORD;
    logic [31:0] hwdata  = '0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [7:0]  trig    = '0;   // trigger output levels
    logic [3:0]  lev     = '0;   // local channel events
    logic [3:0]  ext     = '0;   // events of other units
    logic        slow    = 1'b0; // matrix latency select
    logic [3:0]  m_in;
    logic [3:0]  m_out;
    logic [3:0]  l_view;
    logic [31:0] rdv;            // last read data
    int          n_errors = 0;
    int          total_checks = 0;

    // 250 MHz clock
    always #2 hclk = ~hclk;

    // id values chosen arbitrarily; the other id fields keep their zero defaults
    ctsg_top #(.PART_NUM(12'h5a3), .DESIGNER(8'h4c), .DEV_TYPE(8'h14),
        .COMP_CLASS(4'h9), .CID_BYTES(CID)) dut_u (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .trig_out_level(trig), .chan_local_ev(lev), .chan_matrix_in(m_in),
        .chan_matrix_out(m_out), .chan_local_view(l_view));

    // far side: the matrix echoes our channels plus those of other units
    ctsg_matrix_model mtx_u (.hclk(hclk), .hresetn(hresetn), .from_unit(m_out),
        .ext_ev(ext), .slow(slow), .to_unit(m_in));

    // verdict and end of run
    task automatic results();
        if (n_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    // compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // wait for hready at a rising edge, bounded so a stall cannot hang
    task automatic wait_rdy();
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1)
        begin
            n_errors++;
            results();
        end
    endtask : wait_rdy

    // one single transfer: address phase, then data phase
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, input logic [2:0] sz);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= sz;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rdv = hrdata;
        chk("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
    endtask : xfer

    // write immediately followed by a read of the same word, address phases pipelined
    task automatic wr_rd(input logic [31:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= 1'b1;
        hsize  <= HSIZE_WORD;
        wait_rdy();
        hwrite <= 1'b0;
        hwdata <= wd;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        wait_rdy();
        rdv = hrdata;
    endtask : wr_rd

    // read a word and compare it
    task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, '0, HSIZE_WORD);
        chk(nm, rdv, exp);
    endtask : rdc

    // reset values of gate, id fields and gated outputs
    task automatic t_reset();
        rdc("gate", {20'h0, OFS_GATE}, 32'hf);
        rdc("pid3", {20'h0, OFS_PID3}, 32'h0);
        lev <= 4'hf;
        repeat (3) @(posedge hclk);
        chk("mout", {28'h0, m_out}, 32'hf);
    endtask : t_reset

    // identification words, unmapped reads and the fixed trace pin
    task automatic t_id();
        rdc("capability_config", {20'h0, OFS_CAPABILITY_CONFIG}, 32'h0004_0800);
        rdc("component_type", {20'h0, OFS_COMPONENT_TYPE}, 32'h14);
        rdc("pid4", {20'h0, OFS_PID4}, 32'h0);
        rdc("pid0", {20'h0, OFS_PID0}, 32'ha3);
        rdc("pid1", {20'h0, OFS_PID1}, 32'hc5);
        rdc("pid2", {20'h0, OFS_PID2}, 32'h04);
        rdc("pid5", {20'h0, OFS_PID5}, 32'h0);
        rdc("pid6", {20'h0, OFS_PID6}, 32'h0);
        rdc("pid7", {20'h0, OFS_PID7}, 32'h0);
        rdc("cid0", {20'h0, OFS_CID0}, 32'h44);
        rdc("cid1", {20'h0, OFS_CID1}, 32'h95);
        rdc("cid2", {20'h0, OFS_CID2}, 32'h66);
        rdc("cid3", {20'h0, OFS_CID3}, 32'h77);
        rdc("unmapped", 32'h100, 32'h0);
        xfer(1'b1, {20'h0, OFS_TRACE_PSEL}, 32'h1f, HSIZE_WORD);
        rdc("psel", {20'h0, OFS_TRACE_PSEL}, 32'h0);
    endtask : t_id

    // writes to read-only places and a narrow write must change nothing
    task automatic t_ro();
        xfer(1'b1, {20'h0, OFS_PID0}, '1, HSIZE_WORD);
        xfer(1'b1, {20'h0, OFS_CID1}, '1, HSIZE_WORD);
        xfer(1'b1, {20'h0, OFS_TRIG_STAT}, '1, HSIZE_WORD);
        xfer(1'b1, {20'h0, OFS_CHAN_STAT}, '1, HSIZE_WORD);
        xfer(1'b1, {20'h0, OFS_GATE}, 32'h0, 3'h0);
        rdc("pid0 ro", {20'h0, OFS_PID0}, 32'ha3);
        rdc("cid1 ro", {20'h0, OFS_CID1}, 32'h95);
        rdc("gate kept", {20'h0, OFS_GATE}, 32'hf);
    endtask : t_ro

    // trigger and channel status follow their inputs, prompt and slow matrix
    task automatic t_status();
        logic [7:0] tv [4] = '{8'h01, 8'h80, 8'ha5, 8'hff};
        for (int i = 0; i < 4; i++)
        begin
            trig <= tv[i];
            rdc("trig stat", {20'h0, OFS_TRIG_STAT}, {24'h0, tv[i]});
        end
        lev <= 4'h0;
        for (int i = 0; i < 4; i++)
        begin
            ext  <= 4'h1 << i;
            slow <= i[0];
            repeat (6) @(posedge hclk);
            rdc("chan stat", {20'h0, OFS_CHAN_STAT}, 32'h1 << i);
        end
        ext <= 4'h0;
    endtask : t_status

    // every gate code: read-back, matrix output gated, local view untouched
    task automatic t_gate();
        lev <= 4'hf;
        for (int g = 0; g < 16; g++)
        begin
            xfer(1'b1, {20'h0, OFS_GATE}, {28'hfffffff, 4'(g)}, HSIZE_WORD);
            rdc("gate rb", {20'h0, OFS_GATE}, 32'(g));
            repeat (4) @(posedge hclk);
            chk("mout", {28'h0, m_out}, 32'(g));
            chk("lview", {28'h0, l_view}, 32'hf);
        end
        // read in the data phase of the gate write sees the new value
        wr_rd({20'h0, OFS_GATE}, 32'h6);
        chk("gate fwd", rdv, 32'h6);
        xfer(1'b1, {20'h0, OFS_GATE}, 32'h0, HSIZE_WORD);
        lev <= 4'h5;
        repeat (6) @(posedge hclk);
        chk("mout closed", {28'h0, m_out}, 32'h0);
        chk("lview closed", {28'h0, l_view}, 32'h5);
        rdc("no echo", {20'h0, OFS_CHAN_STAT}, 32'h0);
    endtask : t_gate

    // clock enable low stalls the bus and freezes the channel state
    task automatic t_ce();
        ce  <= 1'b0;
        lev <= 4'ha;
        @(posedge hclk);
        chk("stall", {31'h0, hreadyout}, 32'h0);
        chk("frozen", {28'h0, l_view}, 32'h5);
        fork
            begin
                repeat (2) @(posedge hclk);
                ce <= 1'b1;
            end
        join_none
        rdc("gate stall", {20'h0, OFS_GATE}, 32'h0);
    endtask : t_ce

    // reset in mid-run reopens every gate
    task automatic t_rst2();
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc("gate rst2", {20'h0, OFS_GATE}, 32'hf);
        repeat (2) @(posedge hclk);
        chk("mout rst2", {28'h0, m_out}, 32'ha);
    endtask : t_rst2

    // main sequence: reset for ten cycles, then the scenarios
    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_id();
        t_ro();
        t_status();
        t_gate();
        t_ce();
        t_rst2();
        results();
    end
endmodule : ctsg_top_test
